// *** logic/hmpc_top.sv ***
/*
  halt mode power control: arms on the unlock key, halts on the halt
  instruction, freezes clocks and the oscillator, wakes on allowed
  sources, waits on the interval overflow and hands back to the core.
  assumes an avalon-mm master on clk and a core that pulses halt_exec
  and presents the next instruction address and its interrupt flag.
*/
// Behaviour
// - halted: freeze clocks, hold all state
// - halted: oscillator off, input low, output high
// - halted: ports keep data and direction
// - halted: pc holds address after halt
// - halt only with key pattern armed
// - release clears the key automatically; a key write in that cycle wins instead
// - key is 8-bit write-only, resets zero
// - wake on reset, external, event, serial
// - reset reinits control; interrupt keeps it
// - flag set: vector to service routine
// - flag clear: resume after halt, no vector
// - wake waits 00 to FF overflow
// - halted: interval timer off unless rc mode
// - halted: watchdog off unless rc mode
// - halted: timers stop except event mode
// - halted: serial only with external clock
`timescale 1ns/1ps
`default_nettype none
module hmpc_top
  import hmpc_pkg::*;
#(
  parameter int WAKE_MIN_CYC = WAKE_MIN_CYC_DEF // least settle cycles
) (
  input  wire logic        clk,               // system clock
  input  wire logic        rst,               // async reset, high
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic        halt_exec,         // halt instruction pulse
  input  wire logic [15:0] next_pc,           // address after halt
  input  wire logic        int_enable_flag,   // global interrupt flag
  input  wire logic        ext_int_pin,       // external interrupt
  input  wire logic        event_count_input_zero_irq, // event irq
  input  wire logic        serial_port_a_irq, // serial a irq
  input  wire logic        serial_port_b_irq, // serial b irq
  output logic             core_clk_en,       // clocked functions run
  output logic             osc_run,           // main oscillator on
  output logic             xin_hold_low,      // oscillator in held low
  output logic             xout_hold_high,    // oscillator out held high
  output logic             port_hold,         // ports hold their drive
  output logic             pc_hold,           // program counter held
  output logic      [15:0] held_pc,           // held address
  output logic             bit_run,           // interval timer runs
  output logic             wdt_run,           // watchdog runs
  output logic      [1:0]  tmr_run,           // timer units run
  output logic             serial_port_a_run, // serial a runs
  output logic             serial_port_b_run, // serial b runs
  output logic             vector_req,        // take interrupt, pulse
  output logic             resume_req,        // resume, pulse
  output logic             halted             // in halt or wake
);
  hmpc_state_e    state_r;     // control state
  hmpc_state_e    state_nxt;   // next control state
  logic [3:0]     cause_r;     // last wake cause
  logic [3:0]     cause_nxt;   // next wake cause
  logic [15:0]    pc_nxt;      // next held address
  logic           vec_nxt;     // next vector pulse
  logic           res_nxt;     // next resume pulse
  logic           key_clr;     // clear key on release
  logic           bit_start;   // start the wake count
  logic           bit_done;    // wake count overflow
  logic           bit_busy;    // wake count running
  logic           key_armed;   // key holds the pattern
  logic           key_wr;      // whole-byte key write
  logic [3:0]     sync1_r;     // first synchroniser stage
  logic [3:0]     sync2_r;     // second synchroniser stage
  logic [3:0]     wake_src;    // enabled wake sources
  logic           wake_any;    // any wake source
  logic [CTL_W-1:0] ctrl_r;    // control register
  logic [CTL_W-1:0] ctrl_nxt;  // next control register
  logic           wait_r;      // waitrequest register
  logic           wait_nxt;    // next waitrequest
  logic [31:0]    rdata_r;     // read data register
  logic [31:0]    rdata_nxt;   // next read data
  logic           acc;         // bus access accepted this edge
  logic [3:0]     psel;        // prescaler select
  logic           psel_ok;     // prescaler long enough
  logic           run_nxt;     // core clocks run next
  logic           hlt_nxt;     // oscillator stopped next

  // wake pins come from frozen logic, so resynchronise them
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= (gi == 0) ? ext_int_pin :
                         (gi == 1) ? event_count_input_zero_irq :
                         (gi == 2) ? serial_port_a_irq :
                                     serial_port_b_irq;
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // only sources whose unit keeps running may wake the block
  assign wake_src = {sync2_r[3] & ctrl_r[CTL_SPB_EXT],
                     sync2_r[2] & ctrl_r[CTL_SPA_EXT],
                     sync2_r[1] & ctrl_r[CTL_EVM0],
                     sync2_r[0]};
  assign wake_any = |wake_src;
  assign psel     = ctrl_r[CTL_PSEL_LO +: 4];
  // software must choose the ratio; status shows whether it is enough
  assign psel_ok  = ((32'd256 << psel) > 32'(WAKE_MIN_CYC));

  // halt sequence: entry, release, overflow wait, hand back
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    pc_nxt    = held_pc;
    vec_nxt   = 1'b0;
    res_nxt   = 1'b0;
    key_clr   = 1'b0;
    bit_start = 1'b0;
    case (state_r)
      ST_RUN: begin
        // without the armed key the instruction does nothing
        if (halt_exec && key_armed) begin
          state_nxt = ST_HALT;
          pc_nxt    = next_pc;
        end
      end
      ST_HALT: begin
        if (wake_any) begin
          state_nxt = ST_WAKE;
          cause_nxt = wake_src;
          key_clr   = 1'b1;
          bit_start = 1'b1;
        end
      end
      ST_WAKE: begin
        // oscillator settling; the core stays frozen until overflow
        if (bit_done) begin
          state_nxt = ST_RESUME;
          vec_nxt   = int_enable_flag;
          res_nxt   = !int_enable_flag;
        end
      end
      ST_RESUME: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  assign run_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_RESUME);
  assign hlt_nxt = (state_nxt == ST_HALT);

  // state and freeze outputs, all from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // reset release reinitialises control, memory is outside
      state_r           <= ST_RUN;
      cause_r           <= 4'h0;
      held_pc           <= 16'h0000;
      vector_req        <= 1'b0;
      resume_req        <= 1'b0;
      core_clk_en       <= 1'b1;
      osc_run           <= 1'b1;
      xin_hold_low      <= 1'b0;
      xout_hold_high    <= 1'b0;
      port_hold         <= 1'b0;
      pc_hold           <= 1'b0;
      bit_run           <= 1'b1;
      wdt_run           <= 1'b1;
      tmr_run           <= 2'b11;
      serial_port_a_run <= 1'b1;
      serial_port_b_run <= 1'b1;
      halted            <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      cause_r           <= cause_nxt;
      held_pc           <= pc_nxt;
      vector_req        <= vec_nxt;
      resume_req        <= res_nxt;
      core_clk_en       <= run_nxt;
      osc_run           <= !hlt_nxt;
      xin_hold_low      <= hlt_nxt;
      xout_hold_high    <= hlt_nxt;
      port_hold         <= !run_nxt;
      pc_hold           <= !run_nxt;
      bit_run           <= run_nxt || ctrl_nxt[CTL_RCWD];
      wdt_run           <= run_nxt || ctrl_nxt[CTL_RCWD];
      tmr_run           <= {run_nxt || ctrl_nxt[CTL_EVM1],
                            run_nxt || ctrl_nxt[CTL_EVM0]};
      serial_port_a_run <= run_nxt || ctrl_nxt[CTL_SPA_EXT];
      serial_port_b_run <= run_nxt || ctrl_nxt[CTL_SPB_EXT];
      halted            <= !run_nxt;
    end
  end

  // bus slave: one wait cycle, then the access takes effect
  assign acc    = (avs_read || avs_write) && !wait_r;
  // bit-set style writes that miss the low lane are ignored
  assign key_wr = avs_write && !wait_r && (avs_address == ADDR_KEY) &&
                  avs_byteenable[0];

  always_comb begin
    wait_nxt  = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    if ((avs_read || avs_write) && wait_r && avs_read) begin
      rdata_nxt = 32'h0000_0000; // key and unmapped read zero
      if (avs_address == ADDR_CTRL) begin
        rdata_nxt[CTL_W-1:0] = ctrl_r;
      end else if (avs_address == ADDR_STAT) begin
        rdata_nxt[STA_HALT]            = (state_r == ST_HALT);
        rdata_nxt[STA_WAKE]            = bit_busy;
        rdata_nxt[STA_ARMED]           = key_armed;
        rdata_nxt[STA_PSEL_OK]         = psel_ok;
        rdata_nxt[STA_CAUSE_LO +: 4]   = cause_r;
      end
    end
    // control keeps its value across an interrupt release
    if (acc && avs_write && (avs_address == ADDR_CTRL)) begin
      if (avs_byteenable[0]) begin
        ctrl_nxt[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ctrl_nxt[CTL_W-1:8] = avs_writedata[CTL_W-1:8];
      end
    end
  end

  // bus registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r  <= CTRL_RESET;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  hmpc_key_reg u_key (
    .clk     (clk),
    .rst     (rst),
    .wr_stb  (key_wr),
    .wr_byte (avs_writedata[7:0]),
    .clr     (key_clr),
    .armed   (key_armed)
  );

  hmpc_wake_timer #(.PW(16)) u_bit (
    .clk   (clk),
    .rst   (rst),
    .start (bit_start),
    .psel  (psel),
    .busy  (bit_busy),
    .done  (bit_done)
  );

  property p_no_key;
    @(posedge clk) disable iff (rst)
    (state_r == ST_RUN && halt_exec && !key_armed) |=> core_clk_en;
  endproperty
  a_no_key: assert property (p_no_key)
    else $error("halt taken without armed key");

  property p_enter;
    @(posedge clk) disable iff (rst)
    (state_r == ST_RUN && halt_exec && key_armed)
      |=> (state_r == ST_HALT) && !core_clk_en && held_pc == $past(next_pc);
  endproperty
  a_enter: assert property (p_enter)
    else $error("armed halt did not freeze core");

  property p_osc;
    @(posedge clk) disable iff (rst)
    (state_r == ST_HALT) |-> xin_hold_low && xout_hold_high && !osc_run;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator not held while halted");

  property p_pc;
    @(posedge clk) disable iff (rst)
    (pc_hold && $past(pc_hold)) |-> held_pc == $past(held_pc) && port_hold;
  endproperty
  a_pc: assert property (p_pc)
    else $error("held address or ports moved while halted");

  property p_key_clr;
    @(posedge clk) disable iff (rst)
    (state_r == ST_HALT && wake_any && !key_wr) |=> !key_armed ##0 bit_busy;
  endproperty
  a_key_clr: assert property (p_key_clr)
    else $error("key not cleared on release");

  property p_wait;
    @(posedge clk) disable iff (rst)
    (state_r == ST_WAKE && !bit_done) |=> !core_clk_en;
  endproperty
  a_wait: assert property (p_wait)
    else $error("core restarted before overflow");

  property p_vec;
    @(posedge clk) disable iff (rst)
    (state_r == ST_WAKE && bit_done)
      |=> core_clk_en && (vector_req == $past(int_enable_flag))
          && (resume_req == !$past(int_enable_flag));
  endproperty
  a_vec: assert property (p_vec)
    else $error("wrong vector or resume after wake");

  property p_timers;
    @(posedge clk) disable iff (rst)
    (state_r == ST_HALT) |-> (bit_run == ctrl_r[CTL_RCWD])
      && (wdt_run == ctrl_r[CTL_RCWD]) && (tmr_run[0] == ctrl_r[CTL_EVM0])
      && (serial_port_a_run == ctrl_r[CTL_SPA_EXT]);
  endproperty
  a_timers: assert property (p_timers)
    else $error("peripheral run state wrong while halted");

  property p_wake_src;
    @(posedge clk) disable iff (rst)
    (state_r == ST_HALT && !wake_any) |=> (state_r == ST_HALT);
  endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("left halt without wake source");
endmodule : hmpc_top
`default_nettype wire

// *** inc/hmpc_pkg.sv ***
/*
  constants, register map and state encoding for the halt mode power
  control block. assumes a single 200 MHz clock domain.
*/
`default_nettype none
package hmpc_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [3:0] ADDR_KEY    = 4'h0; // unlock key, write only
  localparam logic [3:0] ADDR_CTRL   = 4'h4; // mode and prescaler control
  localparam logic [3:0] ADDR_STAT   = 4'h8; // block state, read only
  // key register
  localparam logic [7:0] KEY_PATTERN = 8'h5A; // pattern that arms halt
  localparam logic [7:0] KEY_RESET   = 8'h00; // value after reset
  // control register fields
  localparam int CTL_RCWD     = 0;  // rc_watchdog_mode
  localparam int CTL_EVM0     = 1;  // timer 0 in event counter mode
  localparam int CTL_EVM1     = 2;  // timer 1 in event counter mode
  localparam int CTL_SPA_EXT  = 3;  // serial_port_a clocked externally
  localparam int CTL_SPB_EXT  = 4;  // serial_port_b clocked externally
  localparam int CTL_PSEL_LO  = 8;  // prescaler select, 4 bits
  localparam int CTL_W        = 12; // implemented control bits
  localparam logic [11:0] CTRL_RESET = 12'h000; // control after reset
  // status register fields
  localparam int STA_HALT     = 0;  // halted, oscillator stopped
  localparam int STA_WAKE     = 1;  // waiting on the interval overflow
  localparam int STA_ARMED    = 2;  // key currently armed
  localparam int STA_PSEL_OK  = 3;  // prescaler gives a long enough wait
  localparam int STA_CAUSE_LO = 4;  // last wake cause, 4 bits
  // basic interval timer wake count
  localparam logic [7:0] BIT_START = 8'h00; // first count on wake
  localparam logic [7:0] BIT_LAST  = 8'hFF; // count that overflows
  // least oscillator settle time and the cycles it takes
  localparam int WAKE_MIN_MS  = 20;  // milliseconds
  localparam int CLK_MHZ      = 200; // system clock rate
  localparam int WAKE_MIN_CYC_DEF = WAKE_MIN_MS * CLK_MHZ * 1000;
  // control states, one-hot
  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,  // normal operation
    ST_HALT   = 4'h2,  // oscillator stopped, all state held
    ST_WAKE   = 4'h4,  // oscillator back, waiting on overflow
    ST_RESUME = 4'h8   // clocks back, one cycle of vector or resume
  } hmpc_state_e;
endpackage : hmpc_pkg
`default_nettype wire

// *** logic/hmpc_key_reg.sv ***
/*
  unlock key holder: keeps the last byte written and reports whether
  it equals the arming pattern. assumes strobes on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hmpc_key_reg
  import hmpc_pkg::*;
(
  input  wire logic       clk,     // system clock
  input  wire logic       rst,     // async reset, active high
  input  wire logic       wr_stb,  // whole-byte write this cycle
  input  wire logic [7:0] wr_byte, // byte written
  input  wire logic       clr,     // release clears the key
  output logic            armed    // key holds the pattern
);
  logic [7:0] key_r;   // stored key
  logic [7:0] key_nxt; // next stored key

  // a write in the clear cycle wins so the new key is not lost
  always_comb begin
    key_nxt = key_r;
    if (wr_stb) begin
      key_nxt = wr_byte;
    end else if (clr) begin
      key_nxt = KEY_RESET;
    end
  end

  // key storage, zero after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_r <= KEY_RESET;
    end else begin
      key_r <= key_nxt;
    end
  end

  assign armed = (key_r == KEY_PATTERN);
endmodule : hmpc_key_reg
`default_nettype wire

// *** logic/hmpc_wake_timer.sv ***
/*
  wake delay counter: a prescaled 8-bit count from the start value
  up to the last value; the step past the last is the overflow.
  assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hmpc_wake_timer
  import hmpc_pkg::*;
#(
  parameter int PW = 16 // prescaler width
) (
  input  wire logic       clk,   // system clock
  input  wire logic       rst,   // async reset, active high
  input  wire logic       start, // begin a wake count
  input  wire logic [3:0] psel,  // prescale ratio, 2 to the psel
  output logic            busy,  // count in progress
  output logic            done   // overflow pulse, one cycle
);
  logic [PW-1:0] pre_r;     // prescaler count
  logic [PW-1:0] pre_nxt;   // next prescaler count
  logic [7:0]    cnt_r;     // interval count
  logic [7:0]    cnt_nxt;   // next interval count
  logic          busy_nxt;  // next busy
  logic          done_nxt;  // next done
  logic [PW-1:0] mask;      // prescaler wrap mask
  logic          tick;      // one prescaled step

  assign mask = PW'((PW'(1) << psel) - PW'(1));
  assign tick = ((pre_r & mask) == mask);

  // count from the start value, overflow after the last one
  always_comb begin
    pre_nxt  = pre_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy;
    done_nxt = 1'b0;
    if (start) begin
      pre_nxt  = '0;
      cnt_nxt  = BIT_START;
      busy_nxt = 1'b1;
    end else if (busy) begin
      pre_nxt = PW'(pre_r + PW'(1));
      if (tick) begin
        pre_nxt = '0;
        if (cnt_r == BIT_LAST) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = 8'(cnt_r + 8'h01);
        end
      end
    end
  end

  // counter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      cnt_r <= BIT_START;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      busy  <= busy_nxt;
      done  <= done_nxt;
    end
  end
endmodule : hmpc_wake_timer
`default_nettype wire

// *** tb/hmpc_core_model.sv ***
/*
  core model: issues the halt instruction on request, shows the next
  address only while it halts, drives the interrupt flag and counts
  vector and resume pulses. assumes the block's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hmpc_core_model (
  input  wire logic        clk,             // system clock
  input  wire logic        rst,             // async reset, active high
  input  wire logic        go,              // bench asks for a halt
  input  wire logic [15:0] pc_in,           // address after the halt
  input  wire logic        flag_in,         // wanted interrupt flag
  input  wire logic        vector_req,      // vector pulse from block
  input  wire logic        resume_req,      // resume pulse from block
  output logic             halt_exec,       // halt instruction pulse
  output logic      [15:0] next_pc,         // address after the halt
  output logic             int_enable_flag, // global interrupt flag
  output int               n_vec,           // vectors seen
  output int               n_res            // resumes seen
);
  // one-cycle halt; the address is scrambled outside that cycle so a
  // late capture shows up, and the nops after it issue nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_exec       <= 1'b0;
      next_pc         <= 16'h0000;
      int_enable_flag <= 1'b0;
      n_vec           <= 0;
      n_res           <= 0;
    end else begin
      halt_exec       <= go & ~halt_exec;
      next_pc         <= (go & ~halt_exec) ? pc_in : ~next_pc;
      int_enable_flag <= flag_in;
      n_vec           <= n_vec + int'(vector_req);
      n_res           <= n_res + int'(resume_req);
    end
  end
endmodule : hmpc_core_model
`default_nettype wire

// *** tb/test_halt_mode_power_control.sv ***
/*
  bench for the halt mode power control block: bus tasks, halt entry,
  wake by each source and reset in mid-halt. assumes the core model
  and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_halt_mode_power_control;
  import hmpc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, flag = 1'b0;
  logic [3:0]  adr = 4'h0, be = 4'hF;
  logic        rd = 1'b0, wr = 1'b0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic        wait_r, hx, fl, xi, ei, sa, sb, cke, osc, xl, xh;
  logic        ph, pch, br, wr_run, sar, sbr, vq, rq, hl;
  logic [15:0] npc, hpc, pc = 16'h0000;
  logic [3:0]  irq = 4'h0; // serial b, serial a, event, external
  logic [1:0]  tr;
  int          fails = 0, total_checks = 0, nv, nr, n;
  always #2.5 clk = ~clk; // 200 MHz
  hmpc_top #(.WAKE_MIN_CYC(100)) DUT (.clk(clk), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .halt_exec(hx), .next_pc(npc),
    .int_enable_flag(fl), .ext_int_pin(irq[0]),
    .event_count_input_zero_irq(irq[1]), .serial_port_a_irq(irq[2]),
    .serial_port_b_irq(irq[3]), .core_clk_en(cke), .osc_run(osc),
    .xin_hold_low(xl), .xout_hold_high(xh), .port_hold(ph),
    .pc_hold(pch), .held_pc(hpc), .bit_run(br), .wdt_run(wr_run),
    .tmr_run(tr), .serial_port_a_run(sar), .serial_port_b_run(sbr),
    .vector_req(vq), .resume_req(rq), .halted(hl));
  hmpc_core_model core (.clk(clk), .rst(rst), .go(go), .pc_in(pc),
    .flag_in(flag), .vector_req(vq), .resume_req(rq), .halt_exec(hx),
    .next_pc(npc), .int_enable_flag(fl), .n_vec(nv), .n_res(nr));
  // compare and report one value
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    @(posedge clk);
    while (wait_r !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    q = rdata;
    if (k == 40) chk("bus timeout", 32'h1, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  // ask the core for a halt and let entry settle
  task automatic halt(input logic [15:0] p);
    pc <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : halt
  // raise one wake source, then time the vector or resume pulse
  task automatic wake(input int s);
    irq <= 4'(1 << s);
    n = 0;
    repeat (4) @(posedge clk);
    irq <= 4'h0;
    while (!(vq === 1'b1 || rq === 1'b1) && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("wake delay", 32'(n >= 252 && n <= 275), 32'h1);
  endtask : wake
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    #60000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ADDR_KEY, 32'h0);
    chk("key reset", q, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    halt(16'h1234);
    chk("halt no key", {cke, hl}, 32'h2);
    bus(1'b1, ADDR_KEY, 32'(KEY_PATTERN));
    bus(1'b0, ADDR_KEY, 32'h0);
    chk("key write only", q, 32'h0);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("armed", 32'(q[STA_ARMED]), 32'h1);
    flag <= 1'b1;
    halt(16'hA5C3);
    chk("halt outs", {cke, osc, xl, xh, hl}, 32'h07);
    chk("held pc", {pch, ph, hpc}, 32'h3A5C3);
    chk("units off", {br, wr_run, tr, sar, sbr}, 32'h0);
    wake(0);
    chk("vector", {vq, rq, cke, hl}, 32'hA);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("key cleared", 32'(q[STA_ARMED]), 32'h0);
    chk("status", q, 32'h18);
    bus(1'b1, ADDR_CTRL, 32'h01F);
    flag <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, ADDR_KEY, 32'(KEY_PATTERN));
      halt(16'h0100 + 16'(s));
      chk("units kept", {br, wr_run, tr, sar, sbr}, 32'h3F);
      chk("held pc", hpc, 32'h0100 + 32'(s));
      wake(s);
      chk("resume", {vq, rq}, 32'h1);
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl kept", q, 32'h01F);
    end
    chk("pulses", {nv[7:0], nr[7:0]}, 32'h0103);
    bus(1'b1, ADDR_KEY, 32'(KEY_PATTERN));
    halt(16'h0042);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("halt status", q, 32'h8D);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset release", {cke, osc, hl}, 32'h6);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reinit", q, 32'h0);
    stop_test();
  end
endmodule : test_halt_mode_power_control
`default_nettype wire
